// ---- hdl/pph_host_port.sv ----
// parallel host port: strobe decode, address latch, acknowledge
// Function
// - two-bit type select picks latch/strobe, address/data strobe or synchronous styles.
// - eight-bit address decoded directly, no paging, selects one register.
// - one eight-bit data bus, host drives on writes, device on reads.
// - chip select high means read, write and data strobes ignored and registers untouched; the address strobe still latches.
// - latch mode captures address on falling edge of the latch strobe.
// - latch mode starts a read when read strobe falls with chip select low.
// - latch mode starts a write when write strobe falls with chip select low and read strobe does not fall in the same cycle.
// - acknowledge goes low once the access has completed.
// - strobe mode captures address on falling edge of the address strobe.
// - direction high means read, low means write for the data strobe.
// - strobe mode begins access when data strobe falls with chip select low.
// - registers other than the read-only status byte are writable and keep their value for readback.
// - host may poll status or use the interrupt request output.
// - latch strobe tied high makes the address bus transparent.
// - serial select high disables the parallel port.
`timescale 1ns/1ps
`default_nettype none
module pph_host_port import pph_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] interfaceTypeSelect,
    input wire logic serialParallelSelect,
    input wire logic chipSelect_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic addressCaptureStrobe,
    input wire logic readOrDataStrobe_n,
    input wire logic writeStrobeOrDirection,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic transferAck_n,
    input wire logic [DATA_W-1:0] statusIn,
    input wire logic irqRequest,
    output logic hostIrq_n
);
    pph_reg_if regBus ();

    pph_reg_file #(.DEPTH(256)) regFile (
        .clock(clock),
        .rst_n(rst_n),
        .bus(regBus)
    );

    // two-stage synchroniser on every pin; meta is read only by sync
    logic [PIN_W-1:0] meta, sync, next_meta, next_sync;
    logic prevAle, prevRd, prevWr, next_prevAle, next_prevRd, next_prevWr;

    always_comb begin
        next_meta = {chipSelect_n, addressCaptureStrobe, readOrDataStrobe_n,
                     writeStrobeOrDirection, serialParallelSelect,
                     interfaceTypeSelect, address, dataIn};
        next_sync = meta;
        next_prevAle = sync[PIN_W-2];
        next_prevRd = sync[PIN_W-3];
        next_prevWr = sync[PIN_W-4];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta <= PIN_RESET;
            sync <= PIN_RESET;
            prevAle <= 1'b0;
            prevRd <= 1'b1;
            prevWr <= 1'b1;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prevAle <= next_prevAle;
            prevRd <= next_prevRd;
            prevWr <= next_prevWr;
        end
    end

    logic syncCs_n, syncAle, syncRd_n, syncWr, syncSer;
    logic [ADDR_W-1:0] syncAddr;
    logic [DATA_W-1:0] syncData;
    pph_mode_t mode;
    assign syncCs_n = sync[PIN_W-1];
    assign syncAle = sync[PIN_W-2];
    assign syncRd_n = sync[PIN_W-3];
    assign syncWr = sync[PIN_W-4];
    assign syncSer = sync[PIN_W-5];
    assign mode = pph_mode_t'(sync[PIN_W-6 -: 2]);
    assign syncAddr = sync[DATA_W +: ADDR_W];
    assign syncData = sync[DATA_W-1:0];

    logic portOn, csActive, latchMode, aleFall, rdFall, wrFall;
    logic startRead, startWrite, strobeIdle;
    logic [ADDR_W-1:0] effAddr;

    // synchronous styles reuse the address/data strobe handshake
    always_comb begin
        portOn = !syncSer;
        csActive = !syncCs_n && portOn;
        latchMode = (mode == MODE_LATCH);
        aleFall = prevAle && !syncAle;
        rdFall = prevRd && !syncRd_n;
        wrFall = prevWr && !syncWr;
        if (latchMode) begin
            startRead = rdFall;
            startWrite = wrFall && !rdFall;
            strobeIdle = syncRd_n && syncWr;
        end else begin
            startRead = rdFall && syncWr;
            startWrite = rdFall && !syncWr;
            strobeIdle = syncRd_n;
        end
    end

    pph_state_t state, next_state;
    logic isRead, next_isRead, ackN, next_ackN, irqN, next_irqN;
    logic [ADDR_W-1:0] latchedAddr, next_latchedAddr, accessAddr, next_accessAddr;
    logic [DATA_W-1:0] wrData, next_wrData, rdHold, next_rdHold;
    logic accessGo;

    always_comb begin
        next_state = state;
        next_isRead = isRead;
        next_ackN = ackN;
        next_accessAddr = accessAddr;
        next_wrData = wrData;
        next_rdHold = rdHold;
        next_irqN = !irqRequest;
        // latch on falling strobe; held high in latch mode means follow the bus
        next_latchedAddr = aleFall ? syncAddr : latchedAddr;
        effAddr = (latchMode && syncAle) ? syncAddr : latchedAddr;
        accessGo = csActive && (startRead || startWrite);
        regBus.addr = accessAddr;
        regBus.wrData = wrData;
        regBus.wrEn = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (accessGo) begin
                    next_state = ST_ACCESS;
                    next_isRead = startRead;
                    next_accessAddr = effAddr;
                    next_wrData = syncData;
                end
            end
            ST_ACCESS: begin
                if (!csActive) begin
                    next_state = ST_IDLE;
                end else begin
                    // status byte is read-only; writes to it are dropped
                    regBus.wrEn = !isRead && (accessAddr != STATUS_ADDR);
                    if (isRead) begin
                        next_rdHold = (accessAddr == STATUS_ADDR) ? statusIn
                                                                   : regBus.rdData;
                    end
                    next_state = ST_ACK;
                    next_ackN = 1'b0;
                end
            end
            ST_ACK: begin
                if (strobeIdle || !csActive) begin
                    next_state = ST_IDLE;
                    next_ackN = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_ackN = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            isRead <= 1'b0;
            ackN <= 1'b1;
            irqN <= 1'b1;
            latchedAddr <= ADDR_RESET;
            accessAddr <= ADDR_RESET;
            wrData <= DATA_RESET;
            rdHold <= DATA_RESET;
        end else begin
            state <= next_state;
            isRead <= next_isRead;
            ackN <= next_ackN;
            irqN <= next_irqN;
            latchedAddr <= next_latchedAddr;
            accessAddr <= next_accessAddr;
            wrData <= next_wrData;
            rdHold <= next_rdHold;
        end
    end

    assign dataOut = rdHold;
    // drive only while a read is acknowledged and still selected
    assign dataOe = (state == ST_ACK) && isRead && !syncCs_n;
    assign transferAck_n = ackN;
    assign hostIrq_n = irqN;

    localparam int ACK_LO = 1;
    localparam int ACK_HI = 9;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_latch_read_start: assert property (
        state == ST_IDLE && csActive && latchMode && rdFall
        |=> state == ST_ACCESS && isRead)
        else $error("read strobe did not start a read");
    a_latch_write_start: assert property (
        state == ST_IDLE && csActive && latchMode && wrFall && !rdFall
        |=> state == ST_ACCESS && !isRead)
        else $error("write strobe did not start a write");
    a_dir_selects_op: assert property (
        state == ST_IDLE && csActive && !latchMode && rdFall
        |=> state == ST_ACCESS && isRead == $past(syncWr))
        else $error("direction not honoured");
    a_ack_latency: assert property (
        state == ST_IDLE && accessGo |-> ##[ACK_LO:ACK_HI] !transferAck_n)
        else $error("acknowledge too late");
    a_ack_holds: assert property (
        !transferAck_n && !strobeIdle && csActive |=> !transferAck_n)
        else $error("acknowledge dropped early");
    a_ack_release: assert property (
        !transferAck_n && strobeIdle |=> transferAck_n ##1 transferAck_n)
        else $error("acknowledge not released");
    a_cs_blocks_write: assert property (
        !csActive |-> !regBus.wrEn)
        else $error("write while deselected");
    a_oe_reads_only: assert property (
        dataOe |-> isRead && !transferAck_n)
        else $error("bus driven outside a read");
    a_addr_capture: assert property (
        aleFall |=> latchedAddr == $past(syncAddr))
        else $error("address not latched");
    a_serial_idle: assert property (
        syncSer && state == ST_IDLE |=> state == ST_IDLE)
        else $error("parallel port active in serial mode");

    c_read_done: cover property (state == ST_ACK && isRead ##1 state == ST_IDLE);
    c_write_done: cover property (regBus.wrEn ##1 !transferAck_n);
    c_ads_read: cover property (!latchMode && dataOe);
    c_transparent: cover property (latchMode && syncAle && accessGo);
endmodule : pph_host_port
`default_nettype wire

// ---- hdl/pph_pkg.sv ----
// shared constants and types for the parallel host port
package pph_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // interface type select codes
    typedef enum logic [1:0] {
        MODE_LATCH = 2'b00,
        MODE_ADS = 2'b01,
        MODE_SYNC_A = 2'b10,
        MODE_SYNC_B = 2'b11
    } pph_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_ACK = 2'b10
    } pph_state_t;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    // pin vector: cs_n, strobe, read_or_data_strobe_n, wr_n or dir, serial sel, mode, addr, data
    localparam int PIN_W = 5 + 2 + ADDR_W + DATA_W;
    // idle pins: cs_n high, latch strobe low, rd/wr high, serial low; no false edge
    localparam logic [PIN_W-1:0] PIN_RESET = {5'h16, 2'h0, 8'h00, 8'h00};
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACK_MAX_NS = 90;
    localparam int ACK_MAX_CYC = ACK_MAX_NS / CLK_PERIOD_NS;
endpackage : pph_pkg

// ---- hdl/pph_reg_if.sv ----
// register file access channel between port logic and storage
`timescale 1ns/1ps
`default_nettype none
interface pph_reg_if;
    import pph_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic wrEn;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    modport initiator (output addr, output wrEn, output wrData, input rdData);
    modport target (input addr, input wrEn, input wrData, output rdData);
endinterface : pph_reg_if
`default_nettype wire

// ---- hdl/pph_reg_file.sv ----
// on-chip read/write configuration registers
`timescale 1ns/1ps
`default_nettype none
module pph_reg_file import pph_pkg::*; #(
    parameter int DEPTH = 256
) (
    input wire logic clock,
    input wire logic rst_n,
    pph_reg_if.target bus
);
    logic [DATA_W-1:0] mem [DEPTH];

    // values stay until rewritten, so the host can read back its setup
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= REG_RESET;
            end
        end else if (bus.wrEn) begin
            mem[bus.addr] <= bus.wrData;
        end
    end

    assign bus.rdData = mem[bus.addr];
endmodule : pph_reg_file
`default_nettype wire

// ---- tb/pph_host_model.sv ----
// host processor model driving the parallel port pins
`timescale 1ns/1ps
`default_nettype none
module pph_host_model import pph_pkg::*; (
    input wire logic clock,
    output logic [1:0] interfaceTypeSelect,
    output logic chipSelect_n,
    output logic [ADDR_W-1:0] address,
    output logic addressCaptureStrobe,
    output logic readOrDataStrobe_n,
    output logic writeStrobeOrDirection,
    output logic [DATA_W-1:0] dataIn,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe,
    input wire logic transferAck_n
);
    initial begin
        interfaceTypeSelect = MODE_LATCH;
        chipSelect_n = 1'b1;
        address = 8'h00;
        addressCaptureStrobe = 1'b0;
        readOrDataStrobe_n = 1'b1;
        writeStrobeOrDirection = 1'b1;
        dataIn = 8'h00;
    end

    // res = {acked, ack still low 3 edges later, bus driven at ack}
    task automatic xfer(input logic [1:0] m, input logic rd, input logic [7:0] a,
        input logic [7:0] wd, input logic csLow, input logic latchHigh,
        output logic [7:0] rdv, output logic [2:0] res, output int lat);
        int n;
        res = 3'h0;
        @(posedge clock);
        // mode and direction settle with cs high, so no false write edge
        interfaceTypeSelect <= m;
        writeStrobeOrDirection <= (m == MODE_LATCH) ? 1'b1 : rd;
        address <= a;
        addressCaptureStrobe <= 1'b1;
        dataIn <= rd ? ~dataIn : wd;
        repeat (4) @(posedge clock);
        chipSelect_n <= ~csLow;
        repeat (4) @(posedge clock);
        addressCaptureStrobe <= latchHigh;
        repeat (4) @(posedge clock);
        if (m == MODE_LATCH && !rd) writeStrobeOrDirection <= 1'b0;
        else readOrDataStrobe_n <= 1'b0;
        lat = 0;
        while (lat < 20 && !res[2]) begin
            @(posedge clock);
            lat++;
            res[2] = (transferAck_n === 1'b0);
        end
        rdv = dataOut;
        res[0] = (dataOe === 1'b1);
        if (res[2]) begin
            repeat (3) @(posedge clock);
            res[1] = (transferAck_n === 1'b0);
        end
        readOrDataStrobe_n <= 1'b1;
        if (m == MODE_LATCH) writeStrobeOrDirection <= 1'b1;
        n = 0;
        while (n < 20 && transferAck_n !== 1'b1) begin
            @(posedge clock);
            n++;
        end
        chipSelect_n <= 1'b1;
        addressCaptureStrobe <= 1'b0;
        // a released bus does not keep its last value
        dataIn <= ~dataIn;
    endtask : xfer
endmodule : pph_host_model
`default_nettype wire

// ---- tb/parallel_cpu_host_port_tb.sv ----
// self-checking bench for the parallel host port
`timescale 1ns/1ps
`default_nettype none
module parallel_cpu_host_port_tb import pph_pkg::*;;
    typedef struct {logic [1:0] m; logic rd; logic [7:0] a; logic [7:0] d;} pph_row_t;
    localparam logic [7:0] STATUS_VAL = 8'h96;
    logic clock, rst_n, serialParallelSelect, irqRequest, hostIrq_n;
    logic [7:0] statusIn, dataIn, dataOut, address;
    logic [1:0] interfaceTypeSelect;
    logic chipSelect_n, addressCaptureStrobe, readOrDataStrobe_n, writeStrobeOrDirection;
    logic dataOe, transferAck_n;
    int numErrors = 0;
    int samplesChecked = 0;
    pph_row_t rows [13] = '{'{2'b00, 1'b0, 8'h00, 8'ha5}, '{2'b01, 1'b0, 8'h7f, 8'h3c},
        '{2'b10, 1'b0, 8'h01, 8'h5a}, '{2'b11, 1'b0, 8'hfe, 8'hc3},
        '{2'b00, 1'b0, 8'hff, 8'h11}, '{2'b00, 1'b1, 8'h7f, 8'h3c},
        '{2'b01, 1'b1, 8'h00, 8'ha5}, '{2'b10, 1'b1, 8'hfe, 8'hc3},
        '{2'b11, 1'b1, 8'h01, 8'h5a}, '{2'b00, 1'b1, 8'hff, STATUS_VAL},
        '{2'b01, 1'b1, 8'h02, 8'h00}, '{2'b00, 1'b0, 8'h02, 8'he7},
        '{2'b01, 1'b1, 8'h02, 8'he7}};

    pph_host_port u_dut (.clock(clock), .rst_n(rst_n), .interfaceTypeSelect(interfaceTypeSelect),
        .serialParallelSelect(serialParallelSelect), .chipSelect_n(chipSelect_n),
        .address(address), .addressCaptureStrobe(addressCaptureStrobe),
        .readOrDataStrobe_n(readOrDataStrobe_n), .writeStrobeOrDirection(writeStrobeOrDirection),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .transferAck_n(transferAck_n),
        .statusIn(statusIn), .irqRequest(irqRequest), .hostIrq_n(hostIrq_n));
    pph_host_model u_host (.clock(clock), .interfaceTypeSelect(interfaceTypeSelect),
        .chipSelect_n(chipSelect_n), .address(address),
        .addressCaptureStrobe(addressCaptureStrobe), .readOrDataStrobe_n(readOrDataStrobe_n),
        .writeStrobeOrDirection(writeStrobeOrDirection), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .transferAck_n(transferAck_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic endSim();
        $display("checks %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : endSim

    task automatic run(input pph_row_t r, input logic csLow, input logic latchHigh,
        input logic expAck);
        logic [7:0] rdv;
        logic [2:0] res;
        int lat;
        u_host.xfer(r.m, r.rd, r.a, r.d, csLow, latchHigh, rdv, res, lat);
        check("acknowledge", {7'h0, res[2]}, {7'h0, expAck});
        if (expAck) begin
            check("ack held", {7'h0, res[1]}, 8'h01);
            check("ack in time", {7'h0, lat <= ACK_MAX_CYC}, 8'h01);
            check("bus drive", {7'h0, res[0]}, {7'h0, r.rd});
            if (r.rd) check("read data", rdv, r.d);
        end
        check("ack idle", {7'h0, transferAck_n}, 8'h01);
        check("bus released", {7'h0, dataOe}, 8'h00);
    endtask : run

    task automatic doReset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("reset ack", {7'h0, transferAck_n}, 8'h01);
        check("reset drive", {7'h0, dataOe}, 8'h00);
        check("reset irq", {7'h0, hostIrq_n}, 8'h01);
        @(posedge clock);
        rst_n <= 1'b1;
    endtask : doReset

    initial begin
        repeat (5000) @(posedge clock);
        numErrors++;
        $display("watchdog expired");
        endSim();
    end

    initial begin
        rst_n = 1'b0;
        serialParallelSelect = 1'b0;
        irqRequest = 1'b0;
        statusIn = STATUS_VAL;
        doReset();
        $display("reset test done");
        foreach (rows[i]) begin
            run(rows[i], 1'b1, 1'b0, 1'b1);
            $display("row %0d done", i);
        end
        // strobes with chip select high must leave the register alone
        run('{2'b00, 1'b0, 8'h00, 8'hff}, 1'b0, 1'b0, 1'b0);
        run('{2'b01, 1'b1, 8'h00, 8'ha5}, 1'b1, 1'b0, 1'b1);
        $display("chip select test done");
        @(posedge clock);
        serialParallelSelect <= 1'b1;
        run('{2'b00, 1'b0, 8'h7f, 8'hff}, 1'b1, 1'b0, 1'b0);
        serialParallelSelect <= 1'b0;
        run('{2'b00, 1'b1, 8'h7f, 8'h3c}, 1'b1, 1'b0, 1'b1);
        $display("serial select test done");
        run('{2'b00, 1'b1, 8'hfe, 8'hc3}, 1'b1, 1'b1, 1'b1);
        $display("transparent address test done");
        @(posedge clock);
        irqRequest <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("irq asserted", {7'h0, hostIrq_n}, 8'h00);
        @(posedge clock);
        irqRequest <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("irq cleared", {7'h0, hostIrq_n}, 8'h01);
        $display("interrupt test done");
        doReset();
        run('{2'b00, 1'b1, 8'h00, 8'h00}, 1'b1, 1'b0, 1'b1);
        $display("mid-run reset test done");
        endSim();
    end
endmodule : parallel_cpu_host_port_tb
`default_nettype wire
